// >>> tso_pkg.sv
// constants, register map and field layout of the segmentation offload engine
// assumes a 32-bit apb master and a byte-wide dma read port on the same clock
//
// Summary of operation
// - offload flag set on a tcp header means the command is split into full frames plus a final frame
// - every frame but the final one carries exactly the maximum payload
// - total payload counts only tcp payload bytes, no header bytes
// - only the offload flag starts segmentation, never the payload size alone
// - with both checksum requests clear, checksum fields go out as supplied
// - psh and fin are cleared in every frame except the final one
// - header is fetched by dma from the start of the first buffer and parsed
// - prototype header is kept on chip in 80 bytes
// - first frame keeps l2 header, sequence and ack as prototype, and ip length unless it is also the final frame
// - ip and tcp options pass untouched in every frame
// - ip checksum is inserted when its request bit is set; the tcp request bit only drives FRM_TCP_CSUM
// - remaining bytes are total minus frames sent times maximum payload
// - ip identification increments for each frame after the first
// - sequence grows by the previous frame payload, modulo two to the 32
// - intermediate frames reuse the first frame header and flags
// - each rewritten header goes through checksum when the ip request bit is set, then out, frame after frame
// - operations up to 64 kilobytes are accepted
// - only tcp is segmented, udp is not
package tso_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_HADDR   = 8'h04;
   localparam logic [7:0] REG_PAYLOAD = 8'h08;
   localparam logic [7:0] REG_STATUS  = 8'h0C;
   localparam int CTRL_GO   = 0;
   localparam int CTRL_SEG  = 1;
   localparam int CTRL_IPC  = 2;
   localparam int CTRL_TCPC = 3;
   localparam int PAY_MAX_LSB = 0;
   localparam int PAY_TOT_LSB = 16;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_ERR  = 2;
   localparam int ST_FRAMES_LSB = 16;
   // ----------------------------------------------------------------
   // header layout
   // ----------------------------------------------------------------
   localparam int         HDR_BYTES   = 80;
   localparam logic [7:0] ETH_TYPE    = 8'h0C;
   localparam logic [7:0] L2_BYTES    = 8'h0E;
   localparam logic [7:0] VLAN_BYTES  = 8'h04;
   localparam logic [15:0] VLAN_TPID  = 16'h8100;
   localparam logic [7:0] IP_LEN      = 8'h02;
   localparam logic [7:0] IP_ID       = 8'h04;
   localparam logic [7:0] IP_PROTO    = 8'h09;
   localparam logic [7:0] IP_CSUM     = 8'h0A;
   localparam logic [7:0] IP_MIN      = 8'h14;
   localparam logic [7:0] PROTO_TCP   = 8'h06;
   localparam logic [7:0] TCP_SEQ     = 8'h04;
   localparam logic [7:0] TCP_DOFF    = 8'h0C;
   localparam logic [7:0] TCP_FLAGS   = 8'h0D;
   localparam logic [7:0] FLAG_PSH    = 8'h08;
   localparam logic [7:0] FLAG_FIN    = 8'h01;
endpackage

// >>> tso_ones_sum.sv
// ones-complement 16-bit accumulator for the ip header checksum
// assumes the caller clears it before a header and adds one word per cycle
`timescale 1ns/100ps
`default_nettype none
module tso_ones_sum (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // words in
   input  wire logic        clr,
   input  wire logic        add,
   input  wire logic [15:0] word,
   // running sum
   output logic      [15:0] sum
);
   typedef struct packed {
      logic [15:0] sum;
   } sum_type;
   sum_type q;
   sum_type n;
   logic [16:0] s17;

   always_comb begin
      n = q;
      s17 = {1'b0, q.sum} + {1'b0, word};
      if (clr) begin
         n.sum = 16'h0000;
      end else if (add) begin
         n.sum = s17[15:0] + {15'h0000, s17[16]};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign sum = q.sum;
endmodule
`default_nettype wire

// >>> tso_engine.sv
// transmit segmentation offload engine: header fetch, parse, per-frame rewrite
// assumes a downstream transmit path that appends FRM_PAYLOAD bytes and does tcp checksum
`timescale 1ns/100ps
`default_nettype none
module tso_engine #(
   parameter int HB = tso_pkg::HDR_BYTES
) (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // header dma read
   output logic             DMA_REQ,
   output logic      [31:0] DMA_ADDR,
   input  wire logic        DMA_ACK,
   input  wire logic [7:0]  DMA_DATA,
   // header stream to transmit path
   output logic             HDR_VALID,
   output logic      [7:0]  HDR_DATA,
   output logic             HDR_LAST,
   input  wire logic        HDR_READY,
   // per-frame information, valid with HDR_VALID
   output logic             FRM_FIRST,
   output logic             FRM_LAST,
   output logic      [15:0] FRM_PAYLOAD,
   output logic             FRM_TCP_CSUM
);
   if (HB < 54 || HB > 255) begin : g_bad_hb
      $error("HB out of range");
   end

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_FETCH = 3'b001,
      S_PARSE = 3'b010,
      S_BUILD = 3'b011,
      S_CSUM  = 3'b100,
      S_EMIT  = 3'b101
   } state_type;

   typedef struct packed {
      state_type          st;
      logic [HB-1:0][7:0] hdr;
      logic [7:0]         cnt;
      logic [7:0]         ip_off;
      logic [7:0]         ihl_w;
      logic [7:0]         tcp_off;
      logic [7:0]         hdr_len;
      logic               seg_req;
      logic               seg;
      logic               ipc;
      logic               tcpc;
      logic [31:0]        haddr;
      logic [15:0]        max_cfg;
      logic [15:0]        tot_cfg;
      logic [15:0]        max;
      logic [15:0]        rem;
      logic [15:0]        pay;
      logic [31:0]        seq;
      logic [15:0]        id;
      logic [7:0]         pflags;
      logic [15:0]        plen;
      logic               first;
      logic               last;
      logic [15:0]        frames;
      logic               busy;
      logic               done;
      logic               err;
      logic               pready;
      logic               pslverr;
      logic [31:0]        prdata;
      logic               dma_req;
      logic [31:0]        dma_addr;
      logic               hdr_valid;
      logic [7:0]         hdr_data;
      logic               hdr_last;
      logic               csum_clr;
      logic               csum_add;
      logic [15:0]        csum_word;
   } eng_type;

   eng_type     q;
   eng_type     n;
   logic [15:0] csum;

   function automatic logic [15:0] get16(input logic [HB-1:0][7:0] h, input logic [7:0] i);
      return {h[i], h[i+8'h01]};
   endfunction

   function automatic logic bad_addr(input logic [7:0] a);
      return !(a == tso_pkg::REG_CTRL || a == tso_pkg::REG_HADDR ||
               a == tso_pkg::REG_PAYLOAD || a == tso_pkg::REG_STATUS);
   endfunction

   tso_ones_sum u_sum (
      .clk  (CLK),
      .rst  (SYS_RST),
      .clr  (q.csum_clr),
      .add  (q.csum_add),
      .word (q.csum_word),
      .sum  (csum)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic [15:0] et;
   logic [7:0]  ipo;
   logic [7:0]  ihl;
   logic [7:0]  tco;
   logic [8:0]  thl;
   logic [8:0]  hlen;
   logic        perr;
   logic        lastf;
   logic [15:0] pay;
   logic [15:0] tl;
   logic [7:0]  ix;

   always_comb begin
      n = q;
      et = get16(q.hdr, tso_pkg::ETH_TYPE);
      ipo = (et == tso_pkg::VLAN_TPID) ? tso_pkg::L2_BYTES + tso_pkg::VLAN_BYTES
                                      : tso_pkg::L2_BYTES;
      ihl = {2'b00, q.hdr[ipo][3:0], 2'b00};
      tco = ipo + ihl;
      // guard the data offset read so a runaway ip header length cannot index past the store
      thl = (tco < 8'(HB) - tso_pkg::TCP_DOFF) ? {3'b000, q.hdr[tco + tso_pkg::TCP_DOFF][7:4], 2'b00}
                                             : 9'h1FF;
      hlen = {1'b0, tco} + thl;
      perr = ihl < tso_pkg::IP_MIN || hlen > 9'(HB) || (q.seg_req && q.max == 16'h0000);
      lastf = ~q.seg | (q.rem <= q.max);
      pay = lastf ? q.rem : q.max;
      tl = lastf ? q.plen - (q.max - pay) : q.plen;
      ix = 8'h00;
      n.pready = 1'b0;
      n.csum_clr = 1'b0;
      n.csum_add = 1'b0;

      // apb: answer one cycle into the access phase, act on the completing edge
      if (PSEL && PENABLE && !q.pready) begin
         n.pready = 1'b1;
         n.pslverr = bad_addr(PADDR);
         case (PADDR)
            tso_pkg::REG_CTRL:    n.prdata = {28'h0000000, q.tcpc, q.ipc, q.seg_req, 1'b0};
            tso_pkg::REG_HADDR:   n.prdata = q.haddr;
            tso_pkg::REG_PAYLOAD: n.prdata = {q.tot_cfg, q.max_cfg};
            tso_pkg::REG_STATUS:  n.prdata = {q.frames, 13'h0000, q.err, q.done, q.busy};
            default:              n.prdata = 32'h00000000;
         endcase
      end
      if (PSEL && PENABLE && q.pready && PWRITE && !bad_addr(PADDR) && !q.busy) begin
         case (PADDR)
            tso_pkg::REG_HADDR:   n.haddr = PWDATA;
            tso_pkg::REG_PAYLOAD: begin
               n.max_cfg = PWDATA[tso_pkg::PAY_MAX_LSB +: 16];
               n.tot_cfg = PWDATA[tso_pkg::PAY_TOT_LSB +: 16];
            end
            tso_pkg::REG_CTRL: begin
               n.seg_req = PWDATA[tso_pkg::CTRL_SEG];
               n.ipc = PWDATA[tso_pkg::CTRL_IPC];
               n.tcpc = PWDATA[tso_pkg::CTRL_TCPC];
               if (PWDATA[tso_pkg::CTRL_GO]) begin
                  n.busy = 1'b1;
                  n.done = 1'b0;
                  n.err = 1'b0;
                  n.max = q.max_cfg;
                  n.rem = q.tot_cfg;
                  n.cnt = 8'h00;
                  n.dma_addr = q.haddr;
                  n.dma_req = 1'b1;
                  n.st = S_FETCH;
               end
            end
            default: n.prdata = q.prdata;
         endcase
      end

      case (q.st)
         S_IDLE: begin
         end
         S_FETCH: begin
            if (DMA_ACK) begin
               n.hdr[q.cnt] = DMA_DATA;
               n.cnt = q.cnt + 8'h01;
               n.dma_addr = q.dma_addr + 32'h00000001;
               if (q.cnt == 8'(HB - 1)) begin
                  n.dma_req = 1'b0;
                  n.st = S_PARSE;
               end
            end
         end
         S_PARSE: begin
            n.seg = q.seg_req && q.hdr[ipo + tso_pkg::IP_PROTO] == tso_pkg::PROTO_TCP;
            n.ip_off = ipo;
            n.ihl_w = {1'b0, ihl[7:1]};
            n.tcp_off = tco;
            n.hdr_len = hlen[7:0];
            n.seq = {get16(q.hdr, tco + tso_pkg::TCP_SEQ),
                     get16(q.hdr, tco + tso_pkg::TCP_SEQ + 8'h02)};
            n.id = get16(q.hdr, ipo + tso_pkg::IP_ID);
            n.pflags = q.hdr[tco + tso_pkg::TCP_FLAGS];
            n.plen = get16(q.hdr, ipo + tso_pkg::IP_LEN);
            n.first = 1'b1;
            n.frames = 16'h0000;
            if (perr) begin
               n.err = 1'b1;
               n.done = 1'b1;
               n.busy = 1'b0;
               n.st = S_IDLE;
            end else begin
               n.st = S_BUILD;
            end
         end
         S_BUILD: begin
            n.pay = pay;
            n.last = lastf;
            // only the fields below change; options, l2 and ack bytes stay as fetched
            if (q.seg) begin
               n.hdr[q.tcp_off + tso_pkg::TCP_SEQ] = q.seq[31:24];
               n.hdr[q.tcp_off + tso_pkg::TCP_SEQ + 8'h01] = q.seq[23:16];
               n.hdr[q.tcp_off + tso_pkg::TCP_SEQ + 8'h02] = q.seq[15:8];
               n.hdr[q.tcp_off + tso_pkg::TCP_SEQ + 8'h03] = q.seq[7:0];
               n.hdr[q.ip_off + tso_pkg::IP_ID] = q.id[15:8];
               n.hdr[q.ip_off + tso_pkg::IP_ID + 8'h01] = q.id[7:0];
               n.hdr[q.tcp_off + tso_pkg::TCP_FLAGS] = lastf ? q.pflags
                  : q.pflags & ~(tso_pkg::FLAG_PSH | tso_pkg::FLAG_FIN);
               n.hdr[q.ip_off + tso_pkg::IP_LEN] = tl[15:8];
               n.hdr[q.ip_off + tso_pkg::IP_LEN + 8'h01] = tl[7:0];
            end
            n.cnt = 8'h00;
            n.csum_clr = 1'b1;
            if (q.ipc) begin
               n.hdr[q.ip_off + tso_pkg::IP_CSUM] = 8'h00;
               n.hdr[q.ip_off + tso_pkg::IP_CSUM + 8'h01] = 8'h00;
               n.st = S_CSUM;
            end else begin
               n.hdr_valid = 1'b1;
               n.hdr_data = q.hdr[0];
               n.hdr_last = q.hdr_len == 8'h01;
               n.st = S_EMIT;
            end
         end
         S_CSUM: begin
            // the sum trails the last word by one cycle, hence the extra step
            if (q.cnt < q.ihl_w) begin
               n.csum_add = 1'b1;
               n.csum_word = get16(q.hdr, q.ip_off + {q.cnt[6:0], 1'b0});
               n.cnt = q.cnt + 8'h01;
            end else if (q.cnt == q.ihl_w) begin
               n.cnt = q.cnt + 8'h01;
            end else begin
               n.hdr[q.ip_off + tso_pkg::IP_CSUM] = ~csum[15:8];
               n.hdr[q.ip_off + tso_pkg::IP_CSUM + 8'h01] = ~csum[7:0];
               n.cnt = 8'h00;
               n.hdr_valid = 1'b1;
               n.hdr_data = q.hdr[0];
               n.hdr_last = q.hdr_len == 8'h01;
               n.st = S_EMIT;
            end
         end
         S_EMIT: begin
            if (HDR_READY) begin
               if (q.hdr_last) begin
                  n.hdr_valid = 1'b0;
                  n.rem = q.rem - q.pay;
                  n.seq = q.seq + {16'h0000, q.pay};
                  n.id = q.id + 16'h0001;
                  n.frames = q.frames + 16'h0001;
                  n.first = 1'b0;
                  if (q.last) begin
                     n.busy = 1'b0;
                     n.done = 1'b1;
                     n.st = S_IDLE;
                  end else begin
                     n.st = S_BUILD;
                  end
               end else begin
                  ix = q.cnt + 8'h01;
                  n.cnt = ix;
                  n.hdr_data = q.hdr[ix];
                  n.hdr_last = (ix + 8'h01) == q.hdr_len;
               end
            end
         end
         default: n.st = S_IDLE;
      endcase
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign PRDATA = q.prdata;
   assign PREADY = q.pready;
   assign PSLVERR = q.pslverr;
   assign DMA_REQ = q.dma_req;
   assign DMA_ADDR = q.dma_addr;
   assign HDR_VALID = q.hdr_valid;
   assign HDR_DATA = q.hdr_data;
   assign HDR_LAST = q.hdr_last;
   assign FRM_FIRST = q.first;
   assign FRM_LAST = q.last;
   assign FRM_PAYLOAD = q.pay;
   assign FRM_TCP_CSUM = q.tcpc;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic frm_end;
   assign frm_end = q.st == S_EMIT && HDR_READY && q.hdr_last;

   chk_pay_max: assert property (@(posedge CLK) disable iff (SYS_RST)
      q.hdr_valid && q.seg |-> q.pay <= q.max) else $error("payload above maximum");
   chk_mid_full: assert property (@(posedge CLK) disable iff (SYS_RST)
      q.hdr_valid && q.seg && !q.last |-> q.pay == q.max) else $error("short middle frame");
   chk_flags_clr: assert property (@(posedge CLK) disable iff (SYS_RST)
      q.hdr_valid && q.seg && !q.last |->
      (q.hdr[q.tcp_off + tso_pkg::TCP_FLAGS] & (tso_pkg::FLAG_PSH | tso_pkg::FLAG_FIN)) == 8'h00)
      else $error("psh or fin left set");
   chk_seq_step: assert property (@(posedge CLK) disable iff (SYS_RST)
      frm_end |=> q.seq == $past(q.seq) + {16'h0000, $past(q.pay)}) else $error("sequence step");
   chk_id_step: assert property (@(posedge CLK) disable iff (SYS_RST)
      frm_end |=> q.id == $past(q.id) + 16'h0001) else $error("identification step");
   chk_rem_count: assert property (@(posedge CLK) disable iff (SYS_RST)
      frm_end && !q.last |=> q.rem == $past(q.rem) - $past(q.pay) && q.st == S_BUILD)
      else $error("remaining count");
   chk_no_seg: assert property (@(posedge CLK) disable iff (SYS_RST)
      q.hdr_valid && !q.seg |-> q.first && q.last && q.pay == q.tot_cfg)
      else $error("unsegmented command split");
   chk_hdr_fit: assert property (@(posedge CLK) disable iff (SYS_RST)
      q.st == S_EMIT |-> q.hdr_len <= 8'(HB) && !q.err) else $error("header too large");
   chk_csum_keep: assert property (@(posedge CLK) disable iff (SYS_RST)
      q.st == S_BUILD && !q.ipc |=> q.hdr[q.ip_off + tso_pkg::IP_CSUM] ==
      $past(q.hdr[q.ip_off + tso_pkg::IP_CSUM])) else $error("checksum altered");
   chk_first_mark: assert property (@(posedge CLK) disable iff (SYS_RST)
      q.st == S_PARSE && !perr |=> q.first && q.st == S_BUILD ##1 q.first &&
      (q.st == S_CSUM || q.st == S_EMIT)) else $error("first frame not marked");
endmodule
`default_nettype wire

// >>> tso_host_mem.sv
// host memory model that answers the header dma reads of the offload engine
// assumes the bench fills mem before it starts a command; only a 256-byte window
`timescale 1ns/100ps
`default_nettype none
module tso_host_mem (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // dma read port
   input  wire logic        dma_req,
   input  wire logic [31:0] dma_addr,
   output logic             dma_ack,
   output logic      [7:0]  dma_data,
   // pacing: one grant in four instead of every other cycle
   input  wire logic        slow
);
   logic [7:0] mem [0:255];
   logic [1:0] gap_q;
   // ---------------------------------------------------------------
   // byte grants
   // ---------------------------------------------------------------
   // the whole header set sits in one buffer at dma_addr
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dma_ack  <= 1'b0;
         dma_data <= 8'hA5;
         gap_q    <= 2'h0;
      end else begin
         gap_q <= gap_q + 2'h1;
         if (dma_req && !dma_ack && (!slow || gap_q == 2'h3)) begin
            dma_ack  <= 1'b1;
            dma_data <= mem[dma_addr[7:0]];
         end else begin
            dma_ack  <= 1'b0;
            // a stale byte must never look valid between grants
            dma_data <= ~dma_data;
         end
      end
   end
endmodule
`default_nettype wire

// >>> tso_engine_test.sv
// self-checking bench for the segmentation offload engine
// assumes the host memory model on the dma port; the bench is the header sink
`timescale 1ns/100ps
`default_nettype none
module tso_engine_test;
   logic        CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, DMA_REQ, DMA_ACK;
   logic        HDR_VALID, HDR_LAST, HDR_READY, FRM_FIRST, FRM_LAST, FRM_TCP_CSUM, slow, er;
   logic [7:0]  PADDR, DMA_DATA, HDR_DATA;
   logic [31:0] PWDATA, PRDATA, DMA_ADDR, rd;
   logic [15:0] FRM_PAYLOAD;
   logic [7:0]  pr [0:79];
   logic [7:0]  fb [0:255];
   logic [3:0]  ctl;
   int          num_errors, total_checks, blen, fidx, mx, tot, nf, cyc;
   int          t_mx [5] = '{100, 64, 100, 100, 16000};
   int          t_tot [5] = '{250, 128, 1500, 250, 65535};
   logic [3:0]  t_ctl [5] = '{4'hE, 4'h2, 4'h0, 4'h2, 4'hE};
   logic [7:0]  t_pro [5] = '{8'h06, 8'h06, 8'h06, 8'h11, 8'h06};

   tso_engine dut (.CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
      .PREADY, .PSLVERR, .DMA_REQ, .DMA_ADDR, .DMA_ACK, .DMA_DATA, .HDR_VALID, .HDR_DATA,
      .HDR_LAST, .HDR_READY, .FRM_FIRST, .FRM_LAST, .FRM_PAYLOAD, .FRM_TCP_CSUM);
   tso_host_mem host (.clk(CLK), .rst(SYS_RST), .dma_req(DMA_REQ), .dma_addr(DMA_ADDR),
      .dma_ack(DMA_ACK), .dma_data(DMA_DATA), .slow(slow));

   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic wrap_up();
      if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one transfer; pready is seen at the edge, so release follows that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      // no wait count assumed here: only the watchdog ends a hung transfer
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask
   // 14 byte l2, 20 byte ip, 20 byte tcp with ack, psh and fin set
   task automatic build(input logic [7:0] pro);
      for (int i = 0; i < 80; i++) pr[i] = 8'(i * 7 + 3);
      {pr[12], pr[13], pr[14], pr[15]} = 32'h0800_4500;
      {pr[16], pr[17], pr[18], pr[19]} = {16'(40 + mx), 16'h1234};
      {pr[20], pr[21], pr[22], pr[23]} = {24'h4000_40, pro};
      {pr[24], pr[25], pr[46], pr[47]} = 32'hBEEF_5019;
      {pr[38], pr[39], pr[40], pr[41]} = 32'hFFFF_FFA0;
      {pr[52], pr[53]} = 16'h0000;
      for (int i = 0; i < 80; i++) host.mem[i] = pr[i];
   endtask
   task automatic check_frame();
      logic [31:0] s;
      logic        lst, seg;
      int          pay;
      seg = ctl[1] && pr[23] == 8'h06;
      lst = fidx == nf - 1;
      pay = seg ? (lst ? tot - fidx * mx : mx) : tot;
      chk(32'(blen), 32'h36);
      chk(32'(FRM_FIRST), 32'(fidx == 0));
      chk(32'(FRM_LAST), 32'(lst));
      chk(32'(FRM_PAYLOAD), 32'(pay));
      chk(32'(FRM_TCP_CSUM), 32'(ctl[3]));
      for (int i = 0; i < 54; i++)
         if (!(i inside {[16:19], 24, 25, [38:41], 47})) chk(32'(fb[i]), 32'(pr[i]));
      chk({fb[38], fb[39], fb[40], fb[41]}, 32'hFFFF_FFA0 + 32'(fidx * mx));
      chk(32'({fb[18], fb[19]}), 32'(16'h1234 + (seg ? fidx : 0)));
      chk(32'(fb[47]), 32'((seg && !lst) ? 8'h10 : 8'h19));
      chk(32'({fb[16], fb[17]}), 32'(40 + mx - ((seg && lst) ? mx - pay : 0)));
      s = 32'h0;
      for (int i = 14; i < 34; i += 2) s = s + {fb[i], fb[i + 1]};
      s = s[15:0] + s[31:16];
      s = s[15:0] + s[31:16];
      if (ctl[2]) chk(s, 32'hFFFF);
      else chk(32'({fb[24], fb[25]}), 32'hBEEF);
   endtask
   // ---------------------------------------------------------------
   // header sink, stalls one cycle in three
   // ---------------------------------------------------------------
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      HDR_READY <= (cyc % 3 != 0);
      if (DMA_REQ === 1'b1) chk({DMA_ADDR[31:8], 8'h00}, 32'h0000_3000);
      if (HDR_VALID === 1'b1 && HDR_READY === 1'b1) begin
         fb[blen] = HDR_DATA;
         blen++;
         if (HDR_LAST === 1'b1) begin
            check_frame();
            blen = 0;
            fidx++;
         end
      end
   end
   initial begin
      repeat (50000) @(posedge CLK);
      num_errors++;
      wrap_up();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      SYS_RST = 1'b1;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      slow = 1'b0;
      ctl = 4'h0;
      repeat (6) @(posedge CLK);
      SYS_RST <= 1'b0;
      @(posedge CLK);
      apb(1'b0, tso_pkg::REG_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      for (int c = 0; c < 5; c++) begin
         mx = t_mx[c];
         tot = t_tot[c];
         ctl = t_ctl[c];
         slow <= c[0];
         build(t_pro[c]);
         nf = (ctl[1] && t_pro[c] == 8'h06) ? (tot + mx - 1) / mx : 1;
         fidx = 0;
         apb(1'b1, tso_pkg::REG_HADDR, 32'h3000);
         apb(1'b1, tso_pkg::REG_PAYLOAD, {tot[15:0], mx[15:0]});
         apb(1'b1, tso_pkg::REG_CTRL, {28'h0, ctl | 4'h1});
         // a write while busy must leave the command untouched
         apb(1'b1, tso_pkg::REG_PAYLOAD, 32'h0);
         do begin
            apb(1'b0, tso_pkg::REG_STATUS, 32'h0);
         end while (rd[1] !== 1'b1);
         chk(rd, {nf[15:0], 16'h0002});
         chk(32'(fidx), 32'(nf));
         apb(1'b0, tso_pkg::REG_PAYLOAD, 32'h0);
         chk(rd, {tot[15:0], mx[15:0]});
      end
      wrap_up();
   end
endmodule
`default_nettype wire
